// ===== core/spc2_pkg.sv
// Package for the second serial control register block
// Operation
// R1 - With the bit 7 enable set, a set transmit-buffer-empty flag requests an interrupt.
// R2 - With the bit 6 enable set, a set transmission-done flag requests an interrupt.
// R3 - With the bit 5 enable set, a set receive-buffer-full flag requests an interrupt.
// R4 - With the bit 4 enable set, a set idle-line flag requests an interrupt.
// R5 - The transmitter works only while tx_on is set, and then owns and drives the serial out pin.
// R6 - In single-wire mode the line direction select decides whether the out pin sends or receives.
// R7 - Writing tx_on low then high during a transmission queues one idle character.
// R8 - After tx_on clears, the port keeps the out pin until pending data, idle or break is done.
// R9 - The serial in pin is released when rx_on is low, or when loopback is selected.
// R10 - Writing rx_standby high puts the receiver in standby awaiting the wakeup condition.
// R11 - Wakeup is an idle line when the exit select is low, a set data MSB when it is high.
// R12 - Software sets rx_standby and hardware clears it when the wakeup condition is seen.
// R13 - Writing break_queue high then low queues one break character.
// R14 - While break_queue stays high further breaks of 10/11, or 13/14, bit times are queued.
// R15 - A second break may be queued before software clears break_queue.
// R16 - The control register is readable and writable at any time and resets to zero.
// R17 - The port interrupt is the OR of the four flag and enable products, every cycle.
package spc2_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] SPC2_OFF_CTRL   = 4'h0;
    localparam logic [3:0] SPC2_OFF_STAT   = 4'h4;
    localparam logic [3:0] SPC2_OFF_MASK   = 4'h8;
    localparam logic [3:0] SPC2_OFF_LIVE   = 4'hc;
    localparam logic [7:0] SPC2_CTRL_RESET = 8'h00;
    localparam logic [3:0] SPC2_EVT_RESET  = 4'h0;
    localparam logic [1:0] SPC2_RESP_OKAY  = 2'h0;
    localparam logic [1:0] SPC2_RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int SPC2_B_TXE_IE  = 7;
    localparam int SPC2_B_TXD_IE  = 6;
    localparam int SPC2_B_RXF_IE  = 5;
    localparam int SPC2_B_IDL_IE  = 4;
    localparam int SPC2_B_TX_ON   = 3;
    localparam int SPC2_B_RX_ON   = 2;
    localparam int SPC2_B_STANDBY = 1;
    localparam int SPC2_B_BREAK   = 0;
    // Event bits in status and mask
    localparam int SPC2_E_IDLE_Q  = 0;
    localparam int SPC2_E_BREAK_Q = 1;
    localparam int SPC2_E_WAKE    = 2;
    localparam int SPC2_E_PIN_REL = 3;

    typedef struct packed {
        logic tx_buffer_empty;
        logic tx_done_flag;
        logic rx_buffer_full;
        logic line_quiet_flag;
    } spc2_flags_s;

    typedef struct packed {
        logic loopback_sel;
        logic rx_source_sel;
        logic single_line_dir;
        logic standby_exit_select;
        logic long_break_sel;
    } spc2_cfg_s;

    typedef struct packed {
        logic tx_busy;
        logic char_done;
        logic line_idle_seen;
        logic msb_seen;
    } spc2_xfer_s;
endpackage : spc2_pkg

// ===== core/spc2_ctrl.sv
// Second serial control register with AXI4-Lite access and pin ownership
`timescale 1ns/1ns
module spc2_ctrl (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // AXI4-Lite slave
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Status flags and mode selects from the rest of the port
    input  wire spc2_pkg::spc2_flags_s flags,
    input  wire spc2_pkg::spc2_cfg_s   cfg,
    input  wire spc2_pkg::spc2_xfer_s  xfer,
    // Transmit and receive side controls
    output logic                    tx_enable,
    output logic                    tx_out_oe,
    output logic                    tx_out_drive,
    output logic                    rx_pin_owned,
    output logic                    rx_standby_out,
    output logic                    idle_queued,
    output logic                    break_queued,
    output logic                    long_break,
    // Interrupts
    output logic                    port_irq,
    output logic                    evt_irq
);
    import spc2_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [7:0]  ctrl_ff;
    logic [3:0]  stat_ff;
    logic [3:0]  mask_ff;

    // Held halves of a write, so address and data may arrive in either order
    logic        aw_ff;
    logic        w_ff;
    logic [3:0]  awaddr_ff;
    logic [7:0]  wbyte_ff;
    logic        wbe_ff;

    logic        aw_hit;
    logic        w_hit;
    logic        wr_go;
    logic        rd_go;
    logic        s_axi_awready_q;
    logic        s_axi_wready_q;
    logic        s_axi_arready_q;

    // Read back on the live status word, so declared ahead of the read mux
    logic        tx_pending_ff;
    logic        brk_armed_ff;

    assign aw_hit = s_axi_awvalid && s_axi_awready;
    assign w_hit  = s_axi_wvalid && s_axi_wready;
    // Write commits once both halves are held and no response is pending
    assign wr_go  = aw_ff && w_ff && !s_axi_bvalid;
    assign rd_go  = s_axi_arvalid && s_axi_arready;

    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic wr_known;
    assign wr_ctrl  = wr_go && wbe_ff && (awaddr_ff == SPC2_OFF_CTRL);
    assign wr_stat  = wr_go && wbe_ff && (awaddr_ff == SPC2_OFF_STAT);
    assign wr_mask  = wr_go && wbe_ff && (awaddr_ff == SPC2_OFF_MASK);
    assign wr_known = (awaddr_ff == SPC2_OFF_CTRL) || (awaddr_ff == SPC2_OFF_STAT) ||
                      (awaddr_ff == SPC2_OFF_MASK) || (awaddr_ff == SPC2_OFF_LIVE);

    logic [7:0] rd_byte;
    logic       rd_known;
    assign rd_known = (s_axi_araddr == SPC2_OFF_CTRL) || (s_axi_araddr == SPC2_OFF_STAT) ||
                      (s_axi_araddr == SPC2_OFF_MASK) || (s_axi_araddr == SPC2_OFF_LIVE);
    assign rd_byte  = (s_axi_araddr == SPC2_OFF_CTRL) ? ctrl_ff :
                      (s_axi_araddr == SPC2_OFF_STAT) ? {4'h0, stat_ff} :
                      (s_axi_araddr == SPC2_OFF_MASK) ? {4'h0, mask_ff} :
                      (s_axi_araddr == SPC2_OFF_LIVE) ?
                          {tx_out_oe, xfer.tx_busy, tx_pending_ff, brk_armed_ff, flags} :
                      8'h00;

    assign s_axi_awready = s_axi_awready_q;
    assign s_axi_wready  = s_axi_wready_q;
    assign s_axi_arready = s_axi_arready_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wbyte_ff <= 8'h00;
            wbe_ff <= 1'b0;
            s_axi_awready_q <= 1'b0;
            s_axi_wready_q <= 1'b0;
            s_axi_arready_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPC2_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= SPC2_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            s_axi_awready_q <= !aw_ff && !aw_hit && !s_axi_bvalid;
            s_axi_wready_q  <= !w_ff && !w_hit && !s_axi_bvalid;
            if (aw_hit) begin
                aw_ff <= 1'b1;
                awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (w_hit) begin
                w_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wbe_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? SPC2_RESP_OKAY : SPC2_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready_q <= !s_axi_rvalid && !rd_go && !s_axi_arready_q;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_known ? SPC2_RESP_OKAY : SPC2_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register and queued actions
    // ------------------------------------------------------------
    logic idle_q_ff;
    logic brk_q_ff;
    logic oe_ff;
    logic tx_on_w;
    logic brk_w;
    logic stby_w;
    assign tx_on_w = ctrl_ff[SPC2_B_TX_ON];
    assign brk_w   = ctrl_ff[SPC2_B_BREAK];
    assign stby_w  = ctrl_ff[SPC2_B_STANDBY];

    // Wakeup chosen by the exit select
    logic wake_hit;
    assign wake_hit = stby_w &&
        (cfg.standby_exit_select ? xfer.msb_seen : xfer.line_idle_seen); // R11

    // A 0-then-1 write to tx_on during traffic queues an idle
    logic tx_reen;
    logic idle_req;
    logic brk_req;
    assign tx_reen  = wr_ctrl && wbyte_ff[SPC2_B_TX_ON] && tx_pending_ff && xfer.tx_busy; // R7
    assign idle_req = tx_reen && !idle_q_ff;
    // Rising write arms a break; staying high requeues at each char end
    assign brk_req  = (wr_ctrl && wbyte_ff[SPC2_B_BREAK] && !brk_w) ||
                      (brk_w && xfer.char_done); // R13 R14 R15

    logic [7:0] nxt_ctrl;
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = wbyte_ff; // R16
        end
        // Hardware clear yields to a same-cycle software set
        if (wake_hit && !(wr_ctrl && wbyte_ff[SPC2_B_STANDBY])) begin
            nxt_ctrl[SPC2_B_STANDBY] = 1'b0; // R12
        end
    end

    logic [3:0] evt;
    logic [3:0] nxt_stat;
    assign evt = {(oe_ff && !tx_on_w && !xfer.tx_busy && !idle_q_ff && !brk_q_ff),
                  wake_hit, brk_req, idle_req};
    // Set wins over a write-one clear
    assign nxt_stat = (stat_ff & ~(wr_stat ? wbyte_ff[3:0] : 4'h0)) | evt;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= SPC2_CTRL_RESET; // R16
            stat_ff <= SPC2_EVT_RESET;
            mask_ff <= SPC2_EVT_RESET;
            tx_pending_ff <= 1'b0;
            brk_armed_ff <= 1'b0;
            idle_q_ff <= 1'b0;
            brk_q_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            if (wr_mask) begin
                mask_ff <= wbyte_ff[3:0];
            end
            // Remember that tx_on was written low while traffic ran
            if (wr_ctrl) begin
                tx_pending_ff <= !wbyte_ff[SPC2_B_TX_ON] && tx_on_w && xfer.tx_busy;
            end
            brk_armed_ff <= brk_w;
            if (idle_req) begin
                idle_q_ff <= 1'b1;
            end else if (xfer.char_done) begin
                idle_q_ff <= 1'b0;
            end
            if (brk_req) begin
                brk_q_ff <= 1'b1;
            end else if (xfer.char_done) begin
                brk_q_ff <= 1'b0;
            end
            // Pin held until queued work drains
            oe_ff <= tx_on_w || (oe_ff && (xfer.tx_busy || idle_q_ff || brk_q_ff)); // R5 R8
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic single_wire;
    logic irq_w;
    assign single_wire = cfg.loopback_sel && cfg.rx_source_sel;
    assign irq_w = (flags.tx_buffer_empty && nxt_ctrl[SPC2_B_TXE_IE]) || // R1
                   (flags.tx_done_flag    && nxt_ctrl[SPC2_B_TXD_IE]) || // R2
                   (flags.rx_buffer_full  && nxt_ctrl[SPC2_B_RXF_IE]) || // R3
                   (flags.line_quiet_flag && nxt_ctrl[SPC2_B_IDL_IE]);   // R4

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_enable <= 1'b0;
            tx_out_oe <= 1'b0;
            tx_out_drive <= 1'b0;
            rx_pin_owned <= 1'b0;
            rx_standby_out <= 1'b0;
            idle_queued <= 1'b0;
            break_queued <= 1'b0;
            long_break <= 1'b0;
            port_irq <= 1'b0;
            evt_irq <= 1'b0;
        end else begin
            tx_enable <= nxt_ctrl[SPC2_B_TX_ON]; // R5
            tx_out_oe <= tx_on_w || oe_ff;
            // Single wire: the direction select turns the pin around
            tx_out_drive <= single_wire ? (cfg.single_line_dir && (tx_on_w || oe_ff))
                                        : (tx_on_w || oe_ff); // R6
            rx_pin_owned <= nxt_ctrl[SPC2_B_RX_ON] && !cfg.loopback_sel; // R9
            rx_standby_out <= nxt_ctrl[SPC2_B_STANDBY]; // R10
            idle_queued <= idle_q_ff || idle_req;
            break_queued <= brk_q_ff || brk_req;
            long_break <= cfg.long_break_sel; // R14
            port_irq <= irq_w; // R17
            evt_irq <= |(nxt_stat & mask_ff);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_follows_tie: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
        (flags.tx_buffer_empty && nxt_ctrl[SPC2_B_TXE_IE]) |=> port_irq)
        else $error("tx empty irq missing");
    a_irq_follows_tc: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        (flags.tx_done_flag && nxt_ctrl[SPC2_B_TXD_IE]) |=> port_irq)
        else $error("tx done irq missing");
    a_irq_follows_rx: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
        (flags.rx_buffer_full && nxt_ctrl[SPC2_B_RXF_IE]) |=> port_irq)
        else $error("rx full irq missing");
    a_irq_follows_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
        (flags.line_quiet_flag && nxt_ctrl[SPC2_B_IDL_IE]) |=> port_irq)
        else $error("idle irq missing");
    a_irq_quiet_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
        (nxt_ctrl[7:4] == 4'h0) |=> !port_irq)
        else $error("irq without enable");
    a_pin_held_busy: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        (oe_ff && xfer.tx_busy) |=> tx_out_oe)
        else $error("pin released while busy");
    a_rx_pin_loop: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
        cfg.loopback_sel |=> !rx_pin_owned)
        else $error("rx pin kept in loop mode");
    a_wake_clears: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
        (wake_hit && !wr_ctrl) |=> !ctrl_ff[SPC2_B_STANDBY])
        else $error("standby not cleared on wakeup");
    a_break_rises: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
        (wr_ctrl && wbyte_ff[SPC2_B_BREAK] && !brk_w) |=> break_queued ##1 brk_q_ff)
        else $error("break not queued");

    a_break_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
        (brk_w && xfer.char_done) |=> break_queued)
        else $error("repeat break not queued");

    a_idle_queue: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
        idle_req |=> idle_queued)
        else $error("idle not queued");

    a_wake_msb: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
        (stby_w && cfg.standby_exit_select && xfer.msb_seen && !wr_ctrl) |=> !ctrl_ff[1])
        else $error("msb wakeup missed");

    a_no_wrong_wake: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
        (stby_w && cfg.standby_exit_select && !xfer.msb_seen && !wr_ctrl) |=> ctrl_ff[1])
        else $error("standby left without msb");

    a_standby_out: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
        rx_standby_out == ctrl_ff[SPC2_B_STANDBY])
        else $error("standby output differs");

    a_tx_enable_bit: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        tx_enable == ctrl_ff[SPC2_B_TX_ON])
        else $error("tx enable differs");

    a_oe_with_tx: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        tx_on_w |=> tx_out_oe)
        else $error("pin not owned while on");

    a_release_done: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        (oe_ff && !tx_on_w && !xfer.tx_busy && !idle_q_ff && !brk_q_ff)
        |=> stat_ff[SPC2_E_PIN_REL])
        else $error("pin release not flagged");

    a_rx_pin_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
        !nxt_ctrl[SPC2_B_RX_ON] |=> !rx_pin_owned)
        else $error("rx pin kept while off");

    a_drive_dir: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
        (single_wire && !cfg.single_line_dir) |=> !tx_out_drive)
        else $error("pin driven against direction");

    a_irq_no_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
        (flags == 4'h0) |=> !port_irq)
        else $error("irq without flag");

    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
        wr_ctrl |=> (ctrl_ff[7:2] == $past(wbyte_ff[7:2])))
        else $error("control write lost");

    a_ctrl_steady: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
        (!wr_ctrl && !wake_hit) |=> $stable(ctrl_ff))
        else $error("control changed unasked");

    // Set must win over a same-cycle write-one clear
    a_evt_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (evt != 4'h0) |=> ((stat_ff & $past(evt)) == $past(evt)))
        else $error("event lost");

    a_bvalid_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped");

    a_rvalid_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read response dropped");

    a_aw_refused: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write taken while response pending");

    a_ar_refused: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");

    a_resp_ctrl: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
        (wr_go && (awaddr_ff == SPC2_OFF_CTRL)) |=> (s_axi_bresp == SPC2_RESP_OKAY))
        else $error("control write refused");
endmodule // spc2_ctrl

// ===== test/spc2_remote_model.sv
// Far-side model: character timing and wakeup events seen by the control register
`timescale 1ns/1ns
module spc2_remote_model
    import spc2_pkg::*;
#(
    parameter int CHAR_CYC = 20
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Bench requests: send, idle line, set data msb
    input  wire logic [2:0] req,
    // Transfer events
    output spc2_xfer_s      xfer
);
    // ------------------------------------------------------------
    // Character timer
    // ------------------------------------------------------------
    // A new character starts only on request, so no character runs unasked
    int cnt_ff;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) cnt_ff <= 0;
        else if (req[0] && cnt_ff == 0) cnt_ff <= CHAR_CYC;
        else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
    // Wakeup pulses follow the bench at once
    assign xfer = {cnt_ff != 0, cnt_ff == 1, req[1], req[2]};
endmodule // spc2_remote_model

// ===== test/spc2_ctrl_tb.sv
// Self-checking bench for the second serial control register
`timescale 1ns/1ns
module spc2_ctrl_tb;
    import spc2_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int CC = 20;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    spc2_flags_s flags;
    spc2_cfg_s   cfg;
    spc2_xfer_s  xfer;
    logic        tx_enable, tx_out_oe, tx_out_drive, rx_pin_owned, rx_standby_out;
    logic        idle_queued, break_queued, long_break, port_irq, evt_irq;
    logic [2:0]  req;
    int          num_errors = 0;
    int          checks = 0;
    int          i;

    always #5 sys_clk = ~sys_clk;

    spc2_ctrl spc2_ctrl_inst (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .flags, .cfg, .xfer, .tx_enable, .tx_out_oe, .tx_out_drive, .rx_pin_owned,
        .rx_standby_out, .idle_queued, .break_queued, .long_break, .port_irq, .evt_irq);

    spc2_remote_model #(.CHAR_CYC(CC)) spc2_remote_model_inst (.sys_clk, .sys_rst,
        .req, .xfer);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic go(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chkb(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask

    task automatic pulse(input logic [2:0] m);
        req <= m;
        go(1);
        req <= 3'h0;
    endtask

    // Wait is bounded: no response within 50 cycles counts as an error
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) num_errors++;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) num_errors++;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        flags = '0;
        cfg = '0;
        req = 3'h0;
        go(20);
        sys_rst <= 1'b0;
        go(2);
        rd(4'h0, 32'h0, SPC2_RESP_OKAY);
        rd(4'h2, 32'h0, SPC2_RESP_SLVERR);
        wr(4'h0, 32'h1234_56f6, SPC2_RESP_OKAY);
        rd(4'h0, 32'h0000_00f6, SPC2_RESP_OKAY);
        // Each enable alone with its flag, then the other three enables with that same flag
        for (i = 0; i < 4; i++) begin
            flags <= spc2_flags_s'(4'h1 << i);
            wr(4'h0, 32'h10 << i, SPC2_RESP_OKAY);
            go(2);
            chkb(port_irq, 1'b1);
            wr(4'h0, 32'hf0 ^ (32'h10 << i), SPC2_RESP_OKAY);
            go(2);
            chkb(port_irq, 1'b0);
        end
        flags <= '0;
        wr(4'h0, 32'h0c, SPC2_RESP_OKAY);
        go(2);
        chk({28'h0, tx_enable, tx_out_oe, tx_out_drive, rx_pin_owned}, 32'hf);
        cfg.loopback_sel <= 1'b1;
        go(2);
        chkb(rx_pin_owned, 1'b0);
        cfg.rx_source_sel <= 1'b1;
        go(2);
        chkb(tx_out_drive, 1'b0);
        cfg.single_line_dir <= 1'b1;
        go(2);
        chkb(tx_out_drive, 1'b1);
        cfg <= '0;
        // Off then on again during a character
        pulse(3'b001);
        wr(4'h0, 32'h04, SPC2_RESP_OKAY);
        go(1);
        chkb(tx_out_oe, 1'b1);
        chkb(tx_enable, 1'b0);
        wr(4'h0, 32'h0c, SPC2_RESP_OKAY);
        go(2);
        chkb(idle_queued, 1'b1);
        go(CC + 5);
        chkb(idle_queued, 1'b0);
        rd(4'h4, 32'h1, SPC2_RESP_OKAY);
        wr(4'h4, 32'h1, SPC2_RESP_OKAY);
        pulse(3'b001);
        wr(4'h0, 32'h04, SPC2_RESP_OKAY);
        go(1);
        chkb(tx_out_oe, 1'b1);
        go(CC + 5);
        chkb(tx_out_oe, 1'b0);
        rd(4'h4, 32'h8, SPC2_RESP_OKAY);
        wr(4'h4, 32'h8, SPC2_RESP_OKAY);
        // Break bit held across a character end queues another
        wr(4'h0, 32'h09, SPC2_RESP_OKAY);
        go(2);
        chkb(break_queued, 1'b1);
        pulse(3'b001);
        go(CC + 5);
        chkb(break_queued, 1'b1);
        wr(4'h0, 32'h08, SPC2_RESP_OKAY);
        pulse(3'b001);
        go(CC + 5);
        chkb(break_queued, 1'b0);
        cfg.long_break_sel <= 1'b1;
        go(2);
        chkb(long_break, 1'b1);
        rd(4'h4, 32'h2, SPC2_RESP_OKAY);
        wr(4'h4, 32'h2, SPC2_RESP_OKAY);
        // Standby exits only on the selected condition
        wr(4'h0, 32'h02, SPC2_RESP_OKAY);
        go(2);
        chkb(rx_standby_out, 1'b1);
        pulse(3'b100);
        go(2);
        chkb(rx_standby_out, 1'b1);
        pulse(3'b010);
        go(2);
        chkb(rx_standby_out, 1'b0);
        cfg.standby_exit_select <= 1'b1;
        wr(4'h0, 32'h02, SPC2_RESP_OKAY);
        pulse(3'b010);
        go(2);
        chkb(rx_standby_out, 1'b1);
        pulse(3'b100);
        go(2);
        chkb(rx_standby_out, 1'b0);
        rd(4'h0, 32'h0, SPC2_RESP_OKAY);
        // Event status, mask and clear
        rd(4'h4, 32'hc, SPC2_RESP_OKAY);
        chkb(evt_irq, 1'b0);
        wr(4'h8, 32'h4, SPC2_RESP_OKAY);
        go(2);
        chkb(evt_irq, 1'b1);
        wr(4'h4, 32'hc, SPC2_RESP_OKAY);
        go(2);
        chkb(evt_irq, 1'b0);
        rd(4'h4, 32'h0, SPC2_RESP_OKAY);
        conclude();
    end

    // The full sequence needs well under a thousand cycles
    initial begin
        go(3000);
        num_errors++;
        conclude();
    end
endmodule // spc2_ctrl_tb
